// File: bench/testbench.sv
/*
 self-checking bench for the system configuration register.
 assumes one 50 MHz clock, inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] A = scm_pkg::SCM_REG_ADDR;
  typedef struct {logic [31:0] wd; logic lk; logic [31:0] exp;} scm_row_type;
  logic clock_i, rst_b_i, priv_i, rd_i, wr_i, attr_wr_i, lock, den, ov, abv, blw, hit_seen;
  logic [31:0] addr_i, wdata_i, rdata_o;
  logic [1:0] attr_wdata_i, attr_rdata_o, attr_eff_o;
  logic [2:0] mem_type_o;
  logic hit_o, var_o, up_o, enc_o, npp_o, vmpl_o, blk_o;
  int n_mismatch = 0;
  int checks = 0;
  scm_row_type rows [8] = '{
    '{32'h00000000, 1'b0, 32'h00000000},
    '{32'hFC03FFFF, 1'b0, 32'h00000000},
    '{32'h01000000, 1'b0, 32'h00000000},
    '{32'h00FC0000, 1'b0, 32'h00FC0000},
    '{32'h00000000, 1'b1, 32'h00800000},
    '{32'h00000000, 1'b0, 32'h00000000},
    '{32'h03800000, 1'b0, 32'h03800000},
    '{32'h00000000, 1'b0, 32'h03000000}};
  scm_sys_config dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .priv_i(priv_i), .rd_i(rd_i),
    .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
    .attr_wr_i(attr_wr_i), .attr_wdata_i(attr_wdata_i), .attr_rdata_o(attr_rdata_o),
    .attr_eff_o(attr_eff_o), .smm_config_lock_i(lock), .def_type_en_i(den),
    .def_type_i(3'h1), .above_4g_i(abv), .below_upper_limit_i(blw),
    .range_override_i(ov), .range_type_i(3'h2), .var_io_active_o(var_o),
    .upper_limit_active_o(up_o), .encrypt_en_o(enc_o), .npp_en_o(npp_o),
    .vmpl_en_o(vmpl_o), .msr_wr_block_o(blk_o), .mem_type_o(mem_type_o));
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task acc(input logic w, input logic p, input logic [31:0] a, input logic [31:0] d);
    @(negedge clock_i);
    priv_i = p;
    addr_i = a;
    wdata_i = d;
    wr_i = w;
    rd_i = !w;
    @(posedge clock_i);
    hit_seen = hit_o;
    @(negedge clock_i);
    wr_i = 1'b0;
    rd_i = 1'b0;
  endtask : acc
  task attr(input logic [1:0] d);
    @(negedge clock_i);
    attr_wr_i = 1'b1;
    attr_wdata_i = d;
    @(negedge clock_i);
    attr_wr_i = 1'b0;
  endtask : attr
  task complete_run;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    {rst_b_i, priv_i, rd_i, wr_i, attr_wr_i, lock, den, ov, abv, blw, hit_seen} = 11'h000;
    addr_i = 32'h00000000;
    wdata_i = 32'h00000000;
    attr_wdata_i = 2'h0;
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    foreach (rows[i]) begin
      lock = rows[i].lk;
      acc(1'b1, 1'b1, A, rows[i].wd);
      cmp({vmpl_o, npp_o, enc_o}, rows[i].exp[25:23]);
      cmp({up_o, var_o}, rows[i].exp[21:20]);
      cmp(blk_o, rows[i].exp[24]);
      acc(1'b0, 1'b1, A, 32'h00000000);
      cmp(rdata_o, rows[i].exp);
    end
    $display("test rows done");
    cmp(hit_seen, 1'b1);
    acc(1'b1, 1'b0, A, 32'h00FC0000);
    cmp(hit_seen, 1'b0);
    acc(1'b1, 1'b1, A + 32'h1, 32'h00FC0000);
    cmp(hit_seen, 1'b0);
    acc(1'b0, 1'b1, A, 32'h00000000);
    cmp(rdata_o, 32'h03000000);
    cmp(enc_o, 1'b0);
    $display("test refused access done");
    attr(2'h3);
    acc(1'b1, 1'b1, A, 32'h000C0000);
    cmp(attr_rdata_o, 2'h0);
    attr(2'h3);
    cmp(attr_rdata_o, 2'h3);
    cmp(attr_eff_o, 2'h3);
    acc(1'b1, 1'b1, A, 32'h00080000);
    cmp(attr_eff_o, 2'h0);
    acc(1'b1, 1'b1, A, 32'h00040000);
    cmp(attr_rdata_o, 2'h0);
    cmp(attr_eff_o, 2'h3);
    $display("test attributes done");
    acc(1'b1, 1'b1, A, 32'h00600000);
    den = 1'b1;
    abv = 1'b1;
    blw = 1'b1;
    @(negedge clock_i);
    cmp(mem_type_o, scm_pkg::SCM_TYPE_WB);
    den = 1'b0;
    @(negedge clock_i);
    cmp(mem_type_o, 3'h1);
    den = 1'b1;
    abv = 1'b0;
    @(negedge clock_i);
    cmp(mem_type_o, 3'h1);
    abv = 1'b1;
    blw = 1'b0;
    @(negedge clock_i);
    cmp(mem_type_o, 3'h1);
    blw = 1'b1;
    ov = 1'b1;
    @(negedge clock_i);
    cmp(mem_type_o, 3'h2);
    $display("test memory type done");
    @(negedge clock_i);
    rst_b_i = 1'b0;
    @(negedge clock_i);
    rst_b_i = 1'b1;
    cmp({vmpl_o, npp_o, enc_o, up_o, var_o}, 5'h00);
    acc(1'b0, 1'b1, A, 32'h00000000);
    cmp(rdata_o, scm_pkg::SCM_RESET_VAL);
    cmp(npp_o, 1'b0);
    cmp(attr_eff_o, 2'h0);
    $display("test reset done");
    complete_run();
  end
endmodule : testbench

// File: design/scm_fix_attr.sv
/*
 fixed-range read/write memory attribute bits with modify gating.
 assumes the config register drives the enables each cycle.
*/
`timescale 1ns/1ps
module scm_fix_attr (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // control
  scm_fix_if.store fix,
  // effective attributes
  output logic [1:0] attr_eff_o
);
  logic [1:0] attr_r;
  logic [1:0] attr_nxt;

  always_comb begin
    attr_nxt = attr_r;
    if (fix.wr && fix.mod_en) begin
      attr_nxt = fix.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      attr_r <= scm_pkg::SCM_ATTR_RESET;
    end else begin
      attr_r <= attr_nxt;
    end
  end

  assign fix.rdata = fix.mod_en ? attr_r : 2'h0;
  assign attr_eff_o = fix.attr_en ? attr_r : 2'h0;

  chk_mod_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (fix.wr && !fix.mod_en) |=> attr_r == $past(attr_r))
    else $error("attribute changed while modify disabled");
endmodule : scm_fix_attr

// File: design/scm_fix_if.sv
/*
 interface between the config register and the fixed-range attribute store.
 assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface scm_fix_if;
  logic attr_en;
  logic mod_en;
  logic wr;
  logic [1:0] wdata;
  logic [1:0] rdata;
  modport cfg (output attr_en, output mod_en, output wr, output wdata, input rdata);
  modport store (input attr_en, input mod_en, input wr, input wdata, output rdata);
endinterface : scm_fix_if

// File: design/scm_pkg.sv
/*
 system configuration register package: address, field positions, reset values.
 assumes a 32-bit register reached by privileged register read/write requests.
*/
package scm_pkg;
  localparam logic [31:0] SCM_REG_ADDR = 32'hC0010010;
  localparam int SCM_FIX_EN_BIT = 18;
  localparam int SCM_FIX_MOD_BIT = 19;
  localparam int SCM_VAR_IO_BIT = 20;
  localparam int SCM_TOM2_BIT = 21;
  localparam int SCM_FWB_BIT = 22;
  localparam int SCM_MEME_BIT = 23;
  localparam int SCM_NPP_BIT = 24;
  localparam int SCM_VMPL_BIT = 25;
  localparam logic [31:0] SCM_DEFINED_MASK = 32'h03FC0000;
  localparam logic [31:0] SCM_RESET_VAL = 32'h00000000;
  localparam logic [2:0] SCM_TYPE_WB = 3'h6;
  localparam logic [1:0] SCM_ATTR_RESET = 2'h0;
endpackage : scm_pkg

// File: design/scm_sys_config.sv
/*
 system configuration register with memory-type controls, encryption and paging locks.
 assumes requests come only from privileged register read/write instructions.
*/
// Functional notes
// - register lives at config address C001_0010h, privileged access only.
// - only privileged register read and write instructions reach it.
// - bits 25:18 read/write; 31:26 and 17:0 reserved, read zero.
// - bit 18 enables fixed-range read/write memory attributes.
// - bit 19 clear: attribute writes ignored, reads return zero.
// - bit 20 enables top-of-memory limit and variable io range registers.
// - bit 21 enables upper memory limit register.
// - bit 22 forces write-back default between 4GB and upper limit.
// - forced write-back only while default type enable is one.
// - variable ranges and page attribute table still override forced type.
// - bit 23 enables memory encryption features.
// - with config lock set, encryption enable cannot go one to zero.
// - bit 24 enables nested-paging protection; once set, never changes.
// - protection sets only with encryption set before or same write.
// - once protection set, other registers may be write blocked.
// - once protection set, privilege level enable frozen.
`timescale 1ns/1ps
module scm_sys_config (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // register request
  input wire logic priv_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic hit_o,
  // fixed-range attribute access
  input wire logic attr_wr_i,
  input wire logic [1:0] attr_wdata_i,
  output logic [1:0] attr_rdata_o,
  output logic [1:0] attr_eff_o,
  // memory typing context
  input wire logic smm_config_lock_i,
  input wire logic def_type_en_i,
  input wire logic [2:0] def_type_i,
  input wire logic above_4g_i,
  input wire logic below_upper_limit_i,
  input wire logic range_override_i,
  input wire logic [2:0] range_type_i,
  // enables, write block and memory type to the rest of the core
  output logic var_io_active_o,
  output logic upper_limit_active_o,
  output logic encrypt_en_o,
  output logic npp_en_o,
  output logic vmpl_en_o,
  output logic msr_wr_block_o,
  output logic [2:0] mem_type_o
);
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic sel;
  logic wsel;
  logic [7:0] wf;
  logic meme_old;
  logic npp_old;
  logic meme_new;
  logic npp_new;
  logic [31:0] cur;
  scm_fix_if fix ();

  localparam int LO = scm_pkg::SCM_FIX_EN_BIT;

  assign sel = priv_i && (addr_i == scm_pkg::SCM_REG_ADDR);
  assign wsel = sel && wr_i;
  assign wf = wdata_i[scm_pkg::SCM_VMPL_BIT:LO];
  assign meme_old = cfg_r[scm_pkg::SCM_MEME_BIT-LO];
  assign npp_old = cfg_r[scm_pkg::SCM_NPP_BIT-LO];
  assign hit_o = sel && (rd_i || wr_i);

  always_comb begin
    cfg_nxt = cfg_r;
    meme_new = meme_old;
    npp_new = npp_old;
    if (wsel) begin
      cfg_nxt[5:0] = wf[5:0];
      meme_new = wf[scm_pkg::SCM_MEME_BIT-LO];
      if (meme_old && smm_config_lock_i) begin
        meme_new = 1'b1;
      end
      if (!npp_old) begin
        npp_new = wf[scm_pkg::SCM_NPP_BIT-LO] && meme_new;
        cfg_nxt[scm_pkg::SCM_VMPL_BIT-LO] = wf[scm_pkg::SCM_VMPL_BIT-LO];
      end
      cfg_nxt[scm_pkg::SCM_MEME_BIT-LO] = meme_new;
      cfg_nxt[scm_pkg::SCM_NPP_BIT-LO] = npp_new;
    end
  end

  always_comb begin
    cur = scm_pkg::SCM_RESET_VAL;
    cur[scm_pkg::SCM_VMPL_BIT:LO] = cfg_r;
    rdata_nxt = rdata_r;
    if (sel && rd_i) begin
      rdata_nxt = cur & scm_pkg::SCM_DEFINED_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_r <= scm_pkg::SCM_RESET_VAL[scm_pkg::SCM_VMPL_BIT:LO];
      rdata_r <= scm_pkg::SCM_RESET_VAL;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  assign fix.attr_en = cfg_r[scm_pkg::SCM_FIX_EN_BIT-LO];
  assign fix.mod_en = cfg_r[scm_pkg::SCM_FIX_MOD_BIT-LO];
  assign fix.wr = attr_wr_i;
  assign fix.wdata = attr_wdata_i;
  assign attr_rdata_o = fix.rdata;

  scm_fix_attr u_fix (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .fix(fix),
    .attr_eff_o(attr_eff_o)
  );

  assign var_io_active_o = cfg_r[scm_pkg::SCM_VAR_IO_BIT-LO];
  assign upper_limit_active_o = cfg_r[scm_pkg::SCM_TOM2_BIT-LO];
  assign encrypt_en_o = meme_old;
  assign npp_en_o = npp_old;
  assign vmpl_en_o = cfg_r[scm_pkg::SCM_VMPL_BIT-LO];
  assign msr_wr_block_o = npp_old;

  always_comb begin
    mem_type_o = def_type_i;
    if (range_override_i) begin
      mem_type_o = range_type_i;
    end else if (cfg_r[scm_pkg::SCM_FWB_BIT-LO] && def_type_en_i && above_4g_i
                 && below_upper_limit_i && upper_limit_active_o) begin
      mem_type_o = scm_pkg::SCM_TYPE_WB;
    end
  end

  chk_npp_sticky: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    npp_old |=> npp_old)
    else $error("protection enable cleared");
  chk_npp_needs_enc: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(npp_old) |-> meme_old)
    else $error("protection set without encryption");
  chk_npp_refused: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (wsel && !npp_old && !meme_old && !wf[scm_pkg::SCM_MEME_BIT-LO]) |=> !npp_old)
    else $error("protection set by refused write");
  chk_enc_locked: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (meme_old && smm_config_lock_i) |=> meme_old)
    else $error("locked encryption enable cleared");
  chk_vmpl_frozen: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    npp_old |=> $stable(vmpl_en_o))
    else $error("privilege level enable changed");
  chk_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (rdata_o & ~scm_pkg::SCM_DEFINED_MASK) == 32'h00000000)
    else $error("reserved bits read nonzero");
  chk_write_takes: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    wsel |=> var_io_active_o == $past(wdata_i[scm_pkg::SCM_VAR_IO_BIT]))
    else $error("enable bit not written");
  chk_forced_wb: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!def_type_en_i && !range_override_i) |-> mem_type_o == def_type_i)
    else $error("forced type without default enable");
  chk_unpriv_ignored: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!priv_i) |=> cfg_r == $past(cfg_r))
    else $error("unprivileged write took effect");

  chk_read_value: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (sel && rd_i)
    |=> rdata_o[scm_pkg::SCM_VMPL_BIT:LO] == $past(cfg_r))
    else $error("read data differs from register");

  chk_read_holds: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !(sel && rd_i)
    |=> $stable(rdata_o))
    else $error("read data changed without a read");

  chk_hit_priv: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !priv_i
    |-> !hit_o)
    else $error("unprivileged request hit");

  chk_hit_addr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (addr_i != scm_pkg::SCM_REG_ADDR)
    |-> !hit_o)
    else $error("other address hit");

  chk_addr_ignored: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (addr_i != scm_pkg::SCM_REG_ADDR)
    |=> $stable(cfg_r))
    else $error("other address changed register");

  chk_idle_stable: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !wr_i
    |=> $stable(cfg_r))
    else $error("register changed without a write");

  chk_fix_en_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    wsel
    |=> fix.attr_en == $past(wdata_i[scm_pkg::SCM_FIX_EN_BIT]))
    else $error("attribute enable not written");

  chk_fix_mod_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    wsel
    |=> fix.mod_en == $past(wdata_i[scm_pkg::SCM_FIX_MOD_BIT]))
    else $error("attribute modify enable not written");

  chk_upper_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    wsel
    |=> upper_limit_active_o == $past(wdata_i[scm_pkg::SCM_TOM2_BIT]))
    else $error("upper limit enable not written");

  chk_force_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    wsel
    |=> cfg_r[scm_pkg::SCM_FWB_BIT-LO] == $past(wdata_i[scm_pkg::SCM_FWB_BIT]))
    else $error("forced write-back enable not written");

  chk_enc_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (wsel && !(meme_old && smm_config_lock_i))
    |=> encrypt_en_o == $past(wdata_i[scm_pkg::SCM_MEME_BIT]))
    else $error("encryption enable not written");

  chk_enc_set: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (wsel && wdata_i[scm_pkg::SCM_MEME_BIT])
    |=> encrypt_en_o)
    else $error("encryption enable not set");

  chk_npp_grant: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (wsel && !npp_old && wdata_i[scm_pkg::SCM_NPP_BIT] && wdata_i[scm_pkg::SCM_MEME_BIT])
    |=> npp_en_o)
    else $error("protection not set with encryption");

  chk_npp_needs_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!npp_old && !wsel)
    |=> !npp_old)
    else $error("protection set without a write");

  chk_vmpl_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (wsel && !npp_old)
    |=> vmpl_en_o == $past(wdata_i[scm_pkg::SCM_VMPL_BIT]))
    else $error("privilege level enable not written");

  chk_block_on: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    npp_en_o
    |-> msr_wr_block_o)
    else $error("write block missing under protection");

  chk_block_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !npp_en_o
    |-> !msr_wr_block_o)
    else $error("write block without protection");

  chk_var_io_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !wsel
    |=> $stable(var_io_active_o))
    else $error("io range enable changed without write");

  chk_upper_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !wsel
    |=> $stable(upper_limit_active_o))
    else $error("upper limit enable changed without write");

  chk_vmpl_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !wsel
    |=> $stable(vmpl_en_o))
    else $error("privilege level enable changed without write");

  chk_override_wins: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    range_override_i
    |-> mem_type_o == range_type_i)
    else $error("range override ignored");

  chk_wb_applied: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!range_override_i && def_type_en_i && cfg_r[scm_pkg::SCM_FWB_BIT-LO] && above_4g_i
     && below_upper_limit_i && upper_limit_active_o)
    |-> mem_type_o == scm_pkg::SCM_TYPE_WB)
    else $error("write-back default not forced");

  chk_wb_below_4g: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!range_override_i && !above_4g_i)
    |-> mem_type_o == def_type_i)
    else $error("forced type below 4GB");

  chk_wb_above_limit: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!range_override_i && !below_upper_limit_i)
    |-> mem_type_o == def_type_i)
    else $error("forced type above upper limit");

  chk_wb_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!range_override_i && !cfg_r[scm_pkg::SCM_FWB_BIT-LO])
    |-> mem_type_o == def_type_i)
    else $error("forced type while force disabled");

  chk_upper_gates_wb: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!range_override_i && !upper_limit_active_o)
    |-> mem_type_o == def_type_i)
    else $error("forced type with upper limit off");

  chk_attr_eff_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !fix.attr_en
    |-> attr_eff_o == 2'h0)
    else $error("attributes active while disabled");

  chk_attr_read_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !fix.mod_en
    |-> attr_rdata_o == 2'h0)
    else $error("attributes readable while modify disabled");
endmodule : scm_sys_config
